// ### terminal_decoder_pkg.sv
package terminal_decoder_pkg;
  localparam int TERM_N = 7;
  localparam int FUNC_W = 6;
  localparam int SEG_N = 16;
  localparam int SET_W = 10;
  localparam int FREQ_W = 16;
  localparam int FILT_W = 10;
  localparam int TICK_W = 16;
  // Clock rate and filter time unit
  localparam int CLOCK_MHZ = 25;
  localparam int FILTER_UNIT_US = 1000;
  localparam int TICK_CYCLES = CLOCK_MHZ * FILTER_UNIT_US;
  // Filter time in milliseconds
  localparam logic [FILT_W-1:0] FILTER_MAX_MS = 10'h3e8;
  localparam logic [FILT_W-1:0] FILTER_RESET_MS = 10'h00a;
  // Segment setting in tenths of a percent
  localparam logic [SET_W-1:0] FULL_SCALE = 10'h3e8;
  // Terminal function codes
  localparam logic [FUNC_W-1:0] FN_NONE = 6'h00;
  localparam logic [FUNC_W-1:0] FN_FORWARD = 6'h01;
  localparam logic [FUNC_W-1:0] FN_REVERSE = 6'h02;
  localparam logic [FUNC_W-1:0] FN_SEG0 = 6'h0c;
  localparam logic [FUNC_W-1:0] FN_SEG1 = 6'h0d;
  localparam logic [FUNC_W-1:0] FN_SEG2 = 6'h0e;
  localparam logic [FUNC_W-1:0] FN_SEG3 = 6'h0f;
  localparam logic [FUNC_W-1:0] FN_RAMP0 = 6'h10;
  localparam logic [FUNC_W-1:0] FN_RAMP1 = 6'h11;
  localparam logic [FUNC_W-1:0] FN_MOTOR = 6'h29;
  localparam logic [FUNC_W-1:0] FN_PID = 6'h2b;
  localparam logic [FUNC_W-1:0] FN_FAULT1 = 6'h2c;
  localparam logic [FUNC_W-1:0] FN_FAULT2 = 6'h2d;
  localparam logic [FUNC_W-1:0] FN_ESTOP = 6'h2f;
  localparam logic [FUNC_W-1:0] FN_STOP2 = 6'h30;
  localparam logic [FUNC_W-1:0] FN_DCBRAKE = 6'h31;
  localparam logic [FUNC_W-1:0] FN_RUNCLR = 6'h32;
  localparam logic [FUNC_W-1:0] FN_WIRE = 6'h33;
  localparam logic [FUNC_W-1:0] FN_NOREV = 6'h34;
  // Command modes, ramp pair 4 code and terminal PID gain switch condition
  localparam logic [1:0] MODE_TWO_1 = 2'h0;
  localparam logic [1:0] MODE_TWO_2 = 2'h1;
  localparam logic [1:0] MODE_THREE_1 = 2'h2;
  localparam logic [1:0] MODE_THREE_2 = 2'h3;
  localparam logic [1:0] RAMP_PAIR_4 = 2'h3;
  localparam logic [1:0] PID_BY_TERMINAL = 2'h1;
endpackage : terminal_decoder_pkg

// ### drive_input_terminal_decoder.sv
`timescale 1ns/1ps
module drive_input_terminal_decoder #(
  parameter logic [terminal_decoder_pkg::TICK_W-1:0] TICK_CYCLES =
    terminal_decoder_pkg::TICK_W'(terminal_decoder_pkg::TICK_CYCLES)
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [terminal_decoder_pkg::TERM_N-1:0] terminal_closed,
  input wire logic [terminal_decoder_pkg::TERM_N-1:0] terminal_polarity,
  input wire logic [terminal_decoder_pkg::TERM_N-1:0][terminal_decoder_pkg::FUNC_W-1:0]
    terminal_function,
  input wire logic [terminal_decoder_pkg::FILT_W-1:0] terminal_filter_time,
  input wire logic [1:0] terminal_command_mode,
  input wire logic reverse_prohibit_setting,
  input wire logic [1:0] pid_gain_switch_condition,
  input wire logic [terminal_decoder_pkg::FREQ_W-1:0] maximum_output_frequency,
  input wire logic [terminal_decoder_pkg::SEG_N-1:0][terminal_decoder_pkg::SET_W-1:0]
    segment_setting,
  output logic [terminal_decoder_pkg::TERM_N-1:0] terminal_active,
  output logic [3:0] segment_index,
  output logic [terminal_decoder_pkg::FREQ_W-1:0] segment_frequency,
  output logic [1:0] accel_select,
  output logic [1:0] decel_select,
  output logic motor_set_two,
  output logic pid_gain_set_two,
  output logic user_fault_alarm_one,
  output logic user_fault_alarm_two,
  output logic emergency_stop,
  output logic current_at_limit,
  output logic decel_stop_two,
  output logic dc_brake_request,
  output logic run_time_clear,
  output logic [1:0] effective_command_mode,
  output logic reverse_blocked,
  output logic run_forward,
  output logic run_reverse
);
  import terminal_decoder_pkg::*;

  typedef struct packed {
    logic [TICK_W-1:0] tick_cnt;
    logic [TERM_N-1:0][FILT_W-1:0] hold;
    logic [TERM_N-1:0] filt;
    logic [3:0] seg_idx;
    logic [FREQ_W-1:0] seg_freq;
    logic [1:0] accel_sel;
    logic [1:0] decel_sel;
    logic motor2;
    logic pid2;
    logic fault1;
    logic fault2;
    logic estop;
    logic stop2;
    logic dcbrake;
    logic runclr;
    logic [1:0] mode;
    logic norev;
    logic run_fwd;
    logic run_rev;
  } state_t;

  state_t st_ff;
  state_t nxt_st;
  logic [TERM_N-1:0] raw_active;
  logic tick;

  // Any filtered terminal carrying this function is active
  function automatic logic func_on(input logic [TERM_N-1:0] act,
                                   input logic [TERM_N-1:0][FUNC_W-1:0] fn,
                                   input logic [FUNC_W-1:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < TERM_N; i++) begin
      if (act[i] && fn[i] == code && code != FN_NONE) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction : func_on

  function automatic logic [FREQ_W-1:0] scale_freq(input logic [SET_W-1:0] s,
                                                   input logic [FREQ_W-1:0] mx);
    logic [SET_W-1:0] c;
    logic [25:0] p;
    c = (s > FULL_SCALE) ? FULL_SCALE : s;
    p = 26'(c) * 26'(mx);
    return FREQ_W'(p / 26'(FULL_SCALE));
  endfunction : scale_freq

  assign raw_active = terminal_closed ^ terminal_polarity;
  assign tick = (st_ff.tick_cnt == TICK_CYCLES - 1'b1);

  always_comb begin
    logic [TERM_N-1:0] f;
    logic forward_run_input;
    logic reverse_run_input;
    logic wire_tog;
    logic [1:0] ramp;
    logic [FILT_W-1:0] ftime;
    f = '0;
    forward_run_input = 1'b0;
    reverse_run_input = 1'b0;
    wire_tog = 1'b0;
    ramp = 2'h0;
    ftime = '0;
    nxt_st = st_ff;
    nxt_st.tick_cnt = tick ? '0 : st_ff.tick_cnt + 1'b1;
    ftime = (terminal_filter_time > FILTER_MAX_MS) ? FILTER_MAX_MS : terminal_filter_time;
    // Level must stay changed across ftime filter unit ticks before it is taken; the first tick may come early
    for (int i = 0; i < TERM_N; i++) begin
      if (raw_active[i] == st_ff.filt[i]) begin
        nxt_st.hold[i] = '0;
      end else if (ftime == '0) begin
        nxt_st.filt[i] = raw_active[i];
      end else if (tick) begin
        if (st_ff.hold[i] + 1'b1 >= ftime) begin
          nxt_st.filt[i] = raw_active[i];
          nxt_st.hold[i] = '0;
        end else begin
          nxt_st.hold[i] = st_ff.hold[i] + 1'b1;
        end
      end
    end
    f = st_ff.filt;
    // Unassigned selection bits read as zero through func_on
    nxt_st.seg_idx = {func_on(f, terminal_function, FN_SEG3),
                      func_on(f, terminal_function, FN_SEG2),
                      func_on(f, terminal_function, FN_SEG1),
                      func_on(f, terminal_function, FN_SEG0)};
    nxt_st.seg_freq = scale_freq(segment_setting[st_ff.seg_idx], maximum_output_frequency);
    ramp = {func_on(f, terminal_function, FN_RAMP1),
            func_on(f, terminal_function, FN_RAMP0)};
    nxt_st.stop2 = func_on(f, terminal_function, FN_STOP2);
    nxt_st.accel_sel = ramp;
    nxt_st.decel_sel = nxt_st.stop2 ? RAMP_PAIR_4 : ramp;
    nxt_st.motor2 = func_on(f, terminal_function, FN_MOTOR);
    nxt_st.pid2 = (pid_gain_switch_condition == PID_BY_TERMINAL) &&
                  func_on(f, terminal_function, FN_PID);
    nxt_st.fault1 = func_on(f, terminal_function, FN_FAULT1);
    nxt_st.fault2 = func_on(f, terminal_function, FN_FAULT2);
    nxt_st.estop = func_on(f, terminal_function, FN_ESTOP);
    nxt_st.dcbrake = func_on(f, terminal_function, FN_DCBRAKE);
    nxt_st.runclr = func_on(f, terminal_function, FN_RUNCLR);
    wire_tog = func_on(f, terminal_function, FN_WIRE);
    nxt_st.mode = terminal_command_mode;
    if (wire_tog && !terminal_command_mode[1]) begin
      nxt_st.mode = {1'b1, terminal_command_mode[0]};
    end
    nxt_st.norev = reverse_prohibit_setting || func_on(f, terminal_function, FN_NOREV);
    forward_run_input = func_on(f, terminal_function, FN_FORWARD);
    reverse_run_input = func_on(f, terminal_function, FN_REVERSE);
    nxt_st.run_fwd = 1'b0;
    nxt_st.run_rev = 1'b0;
    unique case (nxt_st.mode)
      MODE_TWO_1: begin
        nxt_st.run_fwd = forward_run_input && !reverse_run_input;
        nxt_st.run_rev = reverse_run_input && !forward_run_input;
      end
      MODE_TWO_2: begin
        nxt_st.run_fwd = forward_run_input && !reverse_run_input;
        nxt_st.run_rev = forward_run_input && reverse_run_input;
      end
      MODE_THREE_1, MODE_THREE_2: begin
        nxt_st.run_fwd = 1'b0;
        nxt_st.run_rev = 1'b0;
      end
    endcase
    if (nxt_st.norev) begin
      nxt_st.run_rev = 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign terminal_active = st_ff.filt;
  assign segment_index = st_ff.seg_idx;
  assign segment_frequency = st_ff.seg_freq;
  assign accel_select = st_ff.accel_sel;
  assign decel_select = st_ff.decel_sel;
  assign motor_set_two = st_ff.motor2;
  assign pid_gain_set_two = st_ff.pid2;
  assign user_fault_alarm_one = st_ff.fault1;
  assign user_fault_alarm_two = st_ff.fault2;
  assign emergency_stop = st_ff.estop;
  assign current_at_limit = st_ff.estop;
  assign decel_stop_two = st_ff.stop2;
  assign dc_brake_request = st_ff.dcbrake;
  assign run_time_clear = st_ff.runclr;
  assign effective_command_mode = st_ff.mode;
  assign reverse_blocked = st_ff.norev;
  assign run_forward = st_ff.run_fwd;
  assign run_reverse = st_ff.run_rev;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // Index rebuilt from each segment code's offset, apart from the decode above
  logic [3:0] seg_seen;
  always_comb begin
    seg_seen = 4'h0;
    for (int i = 0; i < TERM_N; i++) begin
      if (st_ff.filt[i] && terminal_function[i] >= FN_SEG0 &&
          terminal_function[i] <= FN_SEG3) begin
        seg_seen[2'(terminal_function[i] - FN_SEG0)] = 1'b1;
      end
    end
  end

  property p_seg_index;
    1 |=> segment_index == $past(seg_seen);
  endproperty
  a_seg_index: assert property (p_seg_index) else $error("segment index mismatch");

  property p_full_scale;
    (segment_setting[segment_index] >= FULL_SCALE) |=>
      segment_frequency == $past(maximum_output_frequency);
  endproperty
  a_full_scale: assert property (p_full_scale) else $error("full scale not max");

  property p_stop2_decel;
    decel_stop_two |-> decel_select == RAMP_PAIR_4;
  endproperty
  a_stop2_decel: assert property (p_stop2_decel) else $error("stop 2 not ramp 4");

  property p_ramp_follow;
    !decel_stop_two |-> decel_select == accel_select;
  endproperty
  a_ramp_follow: assert property (p_ramp_follow) else $error("ramp pair split");

  property p_estop;
    func_on(st_ff.filt, terminal_function, FN_ESTOP) |=> emergency_stop && current_at_limit;
  endproperty
  a_estop: assert property (p_estop) else $error("emergency stop missed");

  property p_faults;
    func_on(st_ff.filt, terminal_function, FN_FAULT1) &&
      !func_on(st_ff.filt, terminal_function, FN_FAULT2)
      |=> user_fault_alarm_one && !user_fault_alarm_two;
  endproperty
  a_faults: assert property (p_faults) else $error("user fault alarms crossed");

  property p_wire_toggle;
    func_on(st_ff.filt, terminal_function, FN_WIRE) && terminal_command_mode == MODE_TWO_2
      |=> effective_command_mode == MODE_THREE_2;
  endproperty
  a_wire_toggle: assert property (p_wire_toggle) else $error("wire toggle wrong");

  property p_no_reverse;
    reverse_blocked |-> !run_reverse;
  endproperty
  a_no_reverse: assert property (p_no_reverse) else $error("reverse while blocked");

  property p_two_wire_one;
    effective_command_mode == MODE_TWO_1 |-> !(run_forward && run_reverse);
  endproperty
  a_two_wire_one: assert property (p_two_wire_one) else $error("both directions");

  property p_two_wire_two;
    (nxt_st.mode == MODE_TWO_2 && !func_on(st_ff.filt, terminal_function, FN_FORWARD))
      |=> !run_forward && !run_reverse;
  endproperty
  a_two_wire_two: assert property (p_two_wire_two) else $error("run without enable");

  property p_filter_zero;
    terminal_filter_time == '0 && raw_active[0] != st_ff.filt[0]
      |=> terminal_active[0] == $past(raw_active[0]);
  endproperty
  a_filter_zero: assert property (p_filter_zero) else $error("zero filter lagged");

  property p_filter_hold;
    terminal_filter_time != '0 && !tick |=> $stable(terminal_active);
  endproperty
  a_filter_hold: assert property (p_filter_hold) else $error("filter took early");

  property p_motor;
    !func_on(st_ff.filt, terminal_function, FN_MOTOR) |=> !motor_set_two;
  endproperty
  a_motor: assert property (p_motor) else $error("motor set 2 wrongly");

  property p_pid_fixed;
    pid_gain_switch_condition != PID_BY_TERMINAL |=> !pid_gain_set_two;
  endproperty
  a_pid_fixed: assert property (p_pid_fixed) else $error("gain set 2 not by terminal");

  property p_fault_two;
    func_on(st_ff.filt, terminal_function, FN_FAULT2) |=> user_fault_alarm_two;
  endproperty
  a_fault_two: assert property (p_fault_two) else $error("user fault 2 missed");

  property p_dc_brake;
    func_on(st_ff.filt, terminal_function, FN_DCBRAKE) |=> dc_brake_request;
  endproperty
  a_dc_brake: assert property (p_dc_brake) else $error("brake request missed");

  property p_run_clear;
    func_on(st_ff.filt, terminal_function, FN_RUNCLR) |=> run_time_clear;
  endproperty
  a_run_clear: assert property (p_run_clear) else $error("run time clear missed");

  c_run_fwd: cover property (run_forward ##1 run_reverse);
  c_stop2: cover property (decel_stop_two && accel_select != RAMP_PAIR_4);
  c_seg15: cover property (segment_index == 4'hf);
  c_filter: cover property (terminal_filter_time != '0 && $rose(terminal_active[0]));
endmodule : drive_input_terminal_decoder

// ### contact_bank.sv
`timescale 1ns/1ps
module contact_bank (
  input wire logic clock,
  input wire logic [6:0] contact_made,
  input wire logic [6:0] chatter,
  output logic [6:0] terminal_closed
);
  // A chattering contact flips its line for as long as chatter is held
  initial terminal_closed = 7'h00;
  always @(posedge clock) begin
    terminal_closed <= contact_made ^ chatter;
  end
endmodule : contact_bank

// ### testbench.sv
`timescale 1ns/1ps
module testbench;
  import terminal_decoder_pkg::*;
  logic clock, rst, reverse_prohibit_setting;
  logic [TERM_N-1:0] contact_made, chatter, terminal_closed, terminal_polarity, terminal_active;
  logic [TERM_N-1:0][FUNC_W-1:0] terminal_function;
  logic [FILT_W-1:0] terminal_filter_time;
  logic [1:0] terminal_command_mode, pid_gain_switch_condition, accel_select, decel_select;
  logic [1:0] effective_command_mode;
  logic [FREQ_W-1:0] maximum_output_frequency, segment_frequency;
  logic [SEG_N-1:0][SET_W-1:0] segment_setting;
  logic [3:0] segment_index;
  logic motor_set_two, pid_gain_set_two, user_fault_alarm_one, user_fault_alarm_two;
  logic emergency_stop, current_at_limit, decel_stop_two, dc_brake_request, run_time_clear;
  logic reverse_blocked, run_forward, run_reverse;
  logic [9:0] flags;
  int num_errors;
  int comparisons;

  assign flags = {motor_set_two, pid_gain_set_two, user_fault_alarm_one, user_fault_alarm_two,
    emergency_stop, current_at_limit, decel_stop_two, dc_brake_request, run_time_clear,
    reverse_blocked};

  contact_bank contacts (.clock(clock), .contact_made(contact_made), .chatter(chatter),
    .terminal_closed(terminal_closed));

  drive_input_terminal_decoder #(.TICK_CYCLES(16'h0004)) uut (
    .clock(clock), .rst(rst), .terminal_closed(terminal_closed),
    .terminal_polarity(terminal_polarity), .terminal_function(terminal_function),
    .terminal_filter_time(terminal_filter_time), .terminal_command_mode(terminal_command_mode),
    .reverse_prohibit_setting(reverse_prohibit_setting),
    .pid_gain_switch_condition(pid_gain_switch_condition),
    .maximum_output_frequency(maximum_output_frequency), .segment_setting(segment_setting),
    .terminal_active(terminal_active), .segment_index(segment_index),
    .segment_frequency(segment_frequency), .accel_select(accel_select),
    .decel_select(decel_select), .motor_set_two(motor_set_two),
    .pid_gain_set_two(pid_gain_set_two), .user_fault_alarm_one(user_fault_alarm_one),
    .user_fault_alarm_two(user_fault_alarm_two), .emergency_stop(emergency_stop),
    .current_at_limit(current_at_limit), .decel_stop_two(decel_stop_two),
    .dc_brake_request(dc_brake_request), .run_time_clear(run_time_clear),
    .effective_command_mode(effective_command_mode), .reverse_blocked(reverse_blocked),
    .run_forward(run_forward), .run_reverse(run_reverse));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Contacts settle, then filter, decode and scaling stages catch up
  task automatic press(input logic [6:0] m);
    contact_made <= m;
    tick(6);
  endtask : press

  task automatic t_segment;
    terminal_function <= {{3{FN_NONE}}, FN_SEG3, FN_SEG2, FN_SEG1, FN_SEG0};
    for (int i = 0; i < SEG_N; i++) begin
      press(7'(i));
      chk(16'(segment_index), 16'(i));
      chk(segment_frequency, 16'(32'(segment_setting[i]) * 5000 / 1000));
    end
  endtask : t_segment

  task automatic t_ramp;
    terminal_function <= {FN_STOP2, FN_RAMP1, FN_RAMP0, {4{FN_NONE}}};
    for (int i = 0; i < 4; i++) begin
      press({1'b0, 2'(i), 4'hf});
      chk(16'({accel_select, decel_select}), 16'(i * 5));
      chk(16'(segment_index), 16'h0000);
    end
    press(7'h50);
    chk(16'({decel_stop_two, accel_select, decel_select}), 16'h0017);
  endtask : t_ramp

  task automatic t_flags;
    logic [FUNC_W-1:0] code [9] = '{FN_MOTOR, FN_PID, FN_FAULT1, FN_FAULT2, FN_ESTOP,
      FN_STOP2, FN_DCBRAKE, FN_RUNCLR, FN_NOREV};
    logic [9:0] want [9] = '{10'h200, 10'h100, 10'h080, 10'h040, 10'h030, 10'h008,
      10'h004, 10'h002, 10'h001};
    pid_gain_switch_condition <= PID_BY_TERMINAL;
    for (int i = 0; i < 9; i++) begin
      terminal_function <= {{6{FN_NONE}}, code[i]};
      press(7'h00);
      chk(16'(flags), 16'h0000);
      press(7'h01);
      chk(16'(flags), 16'(want[i]));
    end
    terminal_function <= {{6{FN_NONE}}, FN_PID};
    pid_gain_switch_condition <= 2'h0;
    press(7'h01);
    chk(16'(flags), 16'h0000);
  endtask : t_flags

  task automatic t_run;
    terminal_function <= {{4{FN_NONE}}, FN_WIRE, FN_REVERSE, FN_FORWARD};
    for (int m = 0; m < 2; m++) begin
      terminal_command_mode <= 2'(m);
      for (int k = 0; k < 4; k++) begin
        press(7'(k));
        chk(16'({run_forward, run_reverse}), m ? 16'({k == 1, k == 3}) : 16'({k == 1, k == 2}));
        chk(16'(effective_command_mode), 16'(m));
      end
      press(7'h05);
      chk(16'({effective_command_mode, run_forward}), 16'(4 + 2 * m));
    end
    terminal_command_mode <= MODE_TWO_1;
    reverse_prohibit_setting <= 1'b1;
    press(7'h02);
    chk(16'({run_forward, run_reverse, reverse_blocked}), 16'h0001);
    reverse_prohibit_setting <= 1'b0;
  endtask : t_run

  task automatic t_filter;
    terminal_function <= {7{FN_NONE}};
    terminal_polarity <= 7'h01;
    press(7'h00);
    chk(16'(terminal_active), 16'h0001);
    terminal_filter_time <= 10'h002;
    tick(1);
    // A short bounce must never reach the filtered level
    chatter <= 7'h01;
    tick(2);
    chatter <= 7'h00;
    tick(12);
    chk(16'(terminal_active), 16'h0001);
    contact_made <= 7'h01;
    tick(3);
    chk(16'(terminal_active), 16'h0001);
    tick(12);
    chk(16'(terminal_active), 16'h0000);
  endtask : t_filter

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim

  initial begin
    num_errors = 0;
    comparisons = 0;
    rst = 1'b1;
    contact_made = 7'h00;
    chatter = 7'h00;
    terminal_polarity = 7'h00;
    terminal_function = '0;
    terminal_filter_time = 10'h000;
    terminal_command_mode = 2'h0;
    reverse_prohibit_setting = 1'b0;
    pid_gain_switch_condition = 2'h0;
    maximum_output_frequency = 16'h1388;
    for (int i = 0; i < SEG_N; i++) begin
      segment_setting[i] = (i == 15) ? FULL_SCALE : SET_W'(i * 61);
    end
    tick(6);
    chk(16'(flags), 16'h0000);
    rst <= 1'b0;
    tick(2);
    t_segment();
    t_ramp();
    t_flags();
    t_run();
    t_filter();
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    end_sim();
  end
endmodule : testbench
